// ---- verilog/ocd_pkg.sv ----
// Constants and types shared by the opcode decode sequencer files
package ocd_pkg;
  localparam int unsigned ICYC_CLKS = 4;
  localparam logic [1:0]  PH_FIRST  = 2'h0;
  localparam logic [1:0]  PH_LAST   = 2'(ICYC_CLKS - 1);
  localparam logic [7:0]  ZERO_BYTE = 8'h00;
  localparam logic [4:0]  CNT_ONE   = 5'h01;
  localparam logic [1:0]  LEN_ONE   = 2'h1;
  localparam logic [1:0]  LEN_TWO   = 2'h2;
  localparam logic [1:0]  LEN_THREE = 2'h3;
  localparam logic [2:0]  CYC_ONE   = 3'h1;
  localparam logic [2:0]  CYC_TWO   = 3'h2;
  localparam logic [2:0]  CYC_THREE = 3'h3;
  localparam logic [2:0]  CYC_FOUR  = 3'h4;
  localparam logic [2:0]  CYC_FIVE  = 3'h5;
  localparam logic [4:0]  LC_1_1    = {LEN_ONE, CYC_ONE};
  localparam logic [4:0]  LC_1_3    = {LEN_ONE, CYC_THREE};
  localparam logic [4:0]  LC_1_4    = {LEN_ONE, CYC_FOUR};
  localparam logic [4:0]  LC_1_5    = {LEN_ONE, CYC_FIVE};
  localparam logic [4:0]  LC_2_2    = {LEN_TWO, CYC_TWO};
  localparam logic [4:0]  LC_2_3    = {LEN_TWO, CYC_THREE};
  localparam logic [4:0]  LC_3_3    = {LEN_THREE, CYC_THREE};
  localparam logic [4:0]  LC_3_4    = {LEN_THREE, CYC_FOUR};
  // Flag update mask: bit 0 carry, bit 1 aux carry, bit 2 overflow
  localparam logic [2:0]  FLG_NONE  = 3'h0;
  localparam logic [2:0]  FLG_CY    = 3'h1;
  localparam logic [2:0]  FLG_CY_OV = 3'h5;
  localparam logic [2:0]  FLG_ALL   = 3'h7;
  localparam logic [7:0]  OP_NOP       = 8'h00;
  localparam logic [7:0]  OP_NOP_ALT   = 8'hA5;
  localparam logic [7:0]  OP_INC_DPTR  = 8'hA3;
  localparam logic [7:0]  OP_MUL       = 8'hA4;
  localparam logic [7:0]  OP_DIV       = 8'h84;
  localparam logic [7:0]  OP_LJMP      = 8'h02;
  localparam logic [7:0]  OP_LCALL     = 8'h12;
  localparam logic [7:0]  OP_RET       = 8'h22;
  localparam logic [7:0]  OP_RETI      = 8'h32;
  localparam logic [7:0]  OP_JBC       = 8'h10;
  localparam logic [7:0]  OP_JMP_ADPTR = 8'h73;
  localparam logic [7:0]  OP_MOVC_PC   = 8'h83;
  localparam logic [7:0]  OP_MOVC_DPTR = 8'h93;
  localparam logic [7:0]  OP_ANL_DI    = 8'h53;
  localparam logic [7:0]  OP_ORL_DI    = 8'h43;
  localparam logic [7:0]  OP_XRL_DI    = 8'h63;
  localparam logic [7:0]  OP_MOV_DD    = 8'h85;
  localparam logic [7:0]  OP_MOV_DI    = 8'h75;
  localparam logic [7:0]  OP_SJMP      = 8'h80;
  localparam logic [7:0]  OP_DJNZ_D    = 8'hD5;

  typedef enum logic [1:0] {
    OCD_ST_OP   = 2'b00,
    OCD_ST_OPND = 2'b01,
    OCD_ST_EXEC = 2'b11
  } ocd_state_t;

  typedef enum logic [2:0] {
    OCD_MD_NONE, OCD_MD_REG, OCD_MD_IND, OCD_MD_XRI,
    OCD_MD_XDPTR, OCD_MD_CDPTR, OCD_MD_CPC
  } ocd_mode_t;
endpackage

// ---- verilog/ocd_dec_if.sv ----
// Decode bundle between the sequencer and the opcode table
`timescale 1ns/100ps
interface ocd_dec_if;
  import ocd_pkg::*;
  logic [7:0] opcode;
  logic [1:0] len;
  logic [2:0] cyc;
  ocd_mode_t  mode;
  logic [2:0] reg_idx;
  logic       ri_sel;
  logic [2:0] flags;
  logic       bit_clr;
  logic       xwr;
  modport lut (input opcode, output len, cyc, mode, reg_idx, ri_sel,
               flags, bit_clr, xwr);
  modport seq (output opcode, input len, cyc, mode, reg_idx, ri_sel,
               flags, bit_clr, xwr);
endinterface

// ---- verilog/ocd_icyc_div.sv ----
// Four-clock instruction cycle phase divider
`timescale 1ns/100ps
module ocd_icyc_div import ocd_pkg::*; (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  output logic [1:0]      phase,
  output logic            c1,
  output logic            c4
);
  typedef struct packed {
    logic [1:0] ph;
  } ocd_div_t;

  ocd_div_t d_r;
  ocd_div_t d_nxt;

  always_comb begin
    d_nxt = d_r;
    if (run) begin
      d_nxt.ph = d_r.ph + 2'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      d_r <= '0;
    end else begin
      d_r <= d_nxt;
    end
  end

  assign phase = d_r.ph;
  assign c1    = (d_r.ph == PH_FIRST);
  assign c4    = run && (d_r.ph == PH_LAST);
endmodule

// ---- verilog/ocd_op_table.sv ----
// Opcode lookup: length, cycles, addressing and flag effects
`timescale 1ns/100ps
module ocd_op_table import ocd_pkg::*; (
  ocd_dec_if.lut dec
);
  logic [7:0] o;
  logic [4:0] lc;

  assign o = dec.opcode;

  always_comb begin
    lc = LC_1_1;
    dec.mode = OCD_MD_NONE;
    dec.flags = FLG_NONE;
    dec.reg_idx = o[2:0];
    dec.ri_sel = o[0];
    dec.bit_clr = (o == OP_JBC);
    dec.xwr = o[4];
    if (o[3]) begin
      dec.mode = OCD_MD_REG;
    end else if (o[3:1] == 3'h3) begin
      dec.mode = OCD_MD_IND;
    end
    // First match wins; specific codes precede their column defaults
    casez (o)
      8'b01111???, 8'b10?01???: lc = LC_2_2;
      8'b10111???: lc = LC_3_4;
      8'b11011???: lc = LC_2_3;
      8'b0111011?, 8'b10?0011?: lc = LC_2_2;
      8'b1011011?: lc = LC_3_4;
      8'h?1: lc = LC_2_3;
      OP_MUL, OP_DIV: lc = LC_1_5;
      8'hB4, 8'hB5: lc = LC_3_4;
      OP_DJNZ_D: lc = LC_3_4;
      OP_JBC, 8'h20, 8'h30: lc = LC_3_4;
      OP_LCALL: lc = LC_3_4;
      OP_LJMP: lc = LC_3_4;
      OP_MOV_DI, OP_MOV_DD, 8'h90: lc = LC_3_3;
      OP_ANL_DI, OP_ORL_DI, OP_XRL_DI: lc = LC_3_3;
      OP_NOP_ALT: lc = LC_1_1;
      8'h?5: lc = LC_2_2;
      8'h24, 8'h34, 8'h94: lc = LC_2_2;
      8'h44, 8'h54, 8'h64, 8'h74: lc = LC_2_2;
      OP_SJMP, 8'h40, 8'h50, 8'h60, 8'h70: lc = LC_2_3;
      8'hA0, 8'hB0, 8'hC0, 8'hD0: lc = LC_2_2;
      8'hE0, 8'hF0: begin
        lc = LC_1_3;
        dec.mode = OCD_MD_XDPTR;
      end
      OP_RET, OP_RETI: lc = LC_1_4;
      8'b111?001?: begin
        lc = LC_1_3;
        dec.mode = OCD_MD_XRI;
      end
      8'h?2: lc = LC_2_2;
      OP_JMP_ADPTR, OP_MOVC_DPTR: begin
        lc = LC_1_3;
        dec.mode = OCD_MD_CDPTR;
      end
      OP_MOVC_PC: begin
        lc = LC_1_3;
        dec.mode = OCD_MD_CPC;
      end
      OP_INC_DPTR: lc = LC_1_3;
      default: lc = LC_1_1;
    endcase
    // Add, add-with-carry and subtract touch all three arithmetic flags
    if ((o[7:4] == 4'h2 || o[7:4] == 4'h3 || o[7:4] == 4'h9)
        && (o[3] || o[2])) begin
      dec.flags = FLG_ALL;
    end else if (o[7:4] == 4'hB && (o[3] || o[2])) begin
      dec.flags = FLG_CY;
    end
    case (o)
      OP_MUL, OP_DIV: dec.flags = FLG_CY_OV;
      8'hD4, 8'h13, 8'h33, 8'hC3, 8'hD3, 8'hB3,
      8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2: dec.flags = FLG_CY;
      default: ;
    endcase
    dec.len = lc[4:3];
    dec.cyc = lc[2:0];
  end
endmodule

// ---- verilog/ocd_decode_seq.sv ----
// Opcode decode and instruction-cycle sequencer, top level
`timescale 1ns/100ps
// Overview of operation
// - Accept standard opcodes with reference semantics
// - Status flags updated exactly as reference
// - Add/addc/subb: Rn,@Ri 1/1; direct,immediate 2/2
// - Data pointer increment: one byte, three cycles
// - Logic immediate into direct: three bytes, three cycles
// - Code table reads: one byte, three cycles
// - Ri external moves: paged address, 1/3
// - Pointer external moves: 16-bit address, 1/3
// - Long call: three bytes, four cycles
// - Returns: one byte, four cycles
// - Absolute call/jump: two bytes, three cycles
// - Long jump: three bytes, four cycles
// - Relative and conditional jumps: two bytes, three
// - Bit jumps 3/4; clear variant clears bit
// - Indirect accumulator-plus-pointer jump: one byte, three
// - Compare-and-jump forms: three bytes, four cycles
// - Decrement-jump: register 2/3, direct 3/4
// - No-operation and reserved alias: one byte, one
// - Carry-only ops 1/1; carry with bit 2/2
// - Direct-to-direct and immediate-to-direct moves: 3/3
// - Indirect pointer R0/R1 from low opcode bit
// - Instruction cycle is exactly four clocks; a missing code byte stretches it at its first clock
module ocd_decode_seq import ocd_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        code_valid,
  input  wire logic [7:0]  code_byte,
  output logic             code_ready,
  input  wire logic [7:0]  acc_value,
  input  wire logic [7:0]  ri_value,
  input  wire logic [15:0] dptr_value,
  input  wire logic [15:0] pc_value,
  input  wire logic [7:0]  external_page_high_byte,
  input  wire logic        xpage_en,
  output logic             instr_valid,
  output logic [7:0]       instr_opcode,
  output logic [1:0]       instr_len,
  output logic [2:0]       instr_cycles,
  output ocd_mode_t        instr_mode,
  output logic [2:0]       reg_index,
  output logic             ind_ptr_sel,
  output logic [2:0]       flag_update,
  output logic             bit_clear_on_branch,
  output logic [7:0]       operand1,
  output logic [7:0]       operand2,
  output logic [10:0]      branch_addr11,
  output logic [15:0]      xdata_addr,
  output logic             xdata_rd,
  output logic             xdata_wr,
  output logic [15:0]      code_addr,
  output logic [1:0]       icyc_phase
);
  typedef struct packed {
    ocd_state_t st;
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic       got;
    logic [2:0] cyc_left;
    logic [4:0] cnt;
    logic       vld;
    logic [7:0] o_op;
    logic [7:0] o_b1;
    logic [7:0] o_b2;
    logic [1:0] o_len;
    logic [2:0] o_cyc;
    ocd_mode_t  o_mode;
    logic [2:0] o_reg;
    logic       o_ri;
    logic [2:0] o_flg;
    logic       o_clr;
    logic [15:0] o_xa;
    logic       o_xrd;
    logic       o_xwr;
    logic [15:0] o_ca;
    logic [4:0] o_cnt;
  } ocd_seq_t;

  ocd_seq_t   s_r;
  ocd_seq_t   s_nxt;
  ocd_dec_if  dec ();
  logic [1:0] phase;
  logic       c1;
  logic       c4;
  logic       run;
  logic       take;
  logic       fin;

  ocd_icyc_div u_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .run      (run),
    .phase    (phase),
    .c1       (c1),
    .c4       (c4)
  );

  ocd_op_table u_tab (
    .dec (dec)
  );

  // While waiting for an opcode the table looks at the incoming byte
  assign dec.opcode = (s_r.st == OCD_ST_OP) ? code_byte : s_r.op;

  // One code byte per instruction cycle, only at its first clock
  assign code_ready = (s_r.st != OCD_ST_EXEC) && c1;
  assign take       = code_ready && code_valid;
  // A missing byte freezes the phase, so a cycle never runs short
  assign run        = !(code_ready && !code_valid);
  assign fin        = c4 && (s_r.st != OCD_ST_OP)
                      && (s_r.cyc_left == CYC_ONE);

  always_comb begin
    s_nxt = s_r;
    s_nxt.vld = 1'b0;
    s_nxt.o_xrd = 1'b0;
    s_nxt.o_xwr = 1'b0;
    if (s_r.st != OCD_ST_OP && run) begin
      s_nxt.cnt = s_r.cnt + CNT_ONE;
    end
    case (s_r.st)
      OCD_ST_OP: begin
        if (take) begin
          s_nxt.op = code_byte;
          s_nxt.b1 = ZERO_BYTE;
          s_nxt.b2 = ZERO_BYTE;
          s_nxt.got = 1'b0;
          s_nxt.cyc_left = dec.cyc;
          s_nxt.cnt = CNT_ONE;
          if (dec.len == LEN_ONE) begin
            s_nxt.st = OCD_ST_EXEC;
          end else begin
            s_nxt.st = OCD_ST_OPND;
          end
        end
      end
      OCD_ST_OPND: begin
        if (take) begin
          if (!s_r.got) begin
            s_nxt.b1 = code_byte;
          end else begin
            s_nxt.b2 = code_byte;
          end
          s_nxt.got = 1'b1;
          if (dec.len == LEN_TWO || s_r.got) begin
            s_nxt.st = OCD_ST_EXEC;
          end
        end
      end
      OCD_ST_EXEC: begin
        s_nxt.st = OCD_ST_EXEC;
      end
      default: begin
        s_nxt.st = OCD_ST_OP;
      end
    endcase
    if (fin) begin
      s_nxt.st = OCD_ST_OP;
      s_nxt.vld = 1'b1;
      s_nxt.o_op = s_r.op;
      s_nxt.o_b1 = s_r.b1;
      s_nxt.o_b2 = s_r.b2;
      s_nxt.o_len = dec.len;
      s_nxt.o_cyc = dec.cyc;
      s_nxt.o_mode = dec.mode;
      s_nxt.o_reg = dec.reg_idx;
      s_nxt.o_ri = dec.ri_sel;
      s_nxt.o_flg = dec.flags;
      s_nxt.o_clr = dec.bit_clr;
      s_nxt.o_cnt = s_r.cnt + CNT_ONE;
      s_nxt.o_xa = {ZERO_BYTE, ZERO_BYTE};
      s_nxt.o_ca = {ZERO_BYTE, ZERO_BYTE};
      case (dec.mode)
        OCD_MD_XRI: begin
          // Without paging the upper address byte stays zero
          if (xpage_en) begin
            s_nxt.o_xa = {external_page_high_byte, ri_value};
          end else begin
            s_nxt.o_xa = {ZERO_BYTE, ri_value};
          end
          s_nxt.o_xrd = !dec.xwr;
          s_nxt.o_xwr = dec.xwr;
        end
        OCD_MD_XDPTR: begin
          s_nxt.o_xa = dptr_value;
          s_nxt.o_xrd = !dec.xwr;
          s_nxt.o_xwr = dec.xwr;
        end
        OCD_MD_CDPTR: begin
          s_nxt.o_ca = dptr_value + {ZERO_BYTE, acc_value};
        end
        OCD_MD_CPC: begin
          // Caller supplies the already advanced program counter
          s_nxt.o_ca = pc_value + {ZERO_BYTE, acc_value};
        end
        default: ;
      endcase
    end else if (c4 && s_r.st != OCD_ST_OP) begin
      s_nxt.cyc_left = s_r.cyc_left - CYC_ONE;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign instr_valid         = s_r.vld;
  assign instr_opcode        = s_r.o_op;
  assign instr_len           = s_r.o_len;
  assign instr_cycles        = s_r.o_cyc;
  assign instr_mode          = s_r.o_mode;
  assign reg_index           = s_r.o_reg;
  assign ind_ptr_sel         = s_r.op[0];
  assign flag_update         = s_r.o_flg;
  assign bit_clear_on_branch = s_r.o_clr;
  assign operand1            = s_r.o_b1;
  assign operand2            = s_r.o_b2;
  assign branch_addr11       = {s_r.o_op[7:5], s_r.o_b1};
  assign xdata_addr          = s_r.o_xa;
  assign xdata_rd            = s_r.o_xrd;
  assign xdata_wr            = s_r.o_xwr;
  assign code_addr           = s_r.o_ca;
  assign icyc_phase          = phase;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_r23;
    instr_valid |-> s_r.o_cnt == 5'(s_r.o_cyc * ICYC_CLKS);
  endproperty
  a_r23: assert property (p_r23)
    else $error("instruction clocks differ from four per cycle");

  property p_r04;
    take && s_r.st == OCD_ST_OP && code_byte == OP_INC_DPTR
      |-> ##1 !code_ready [*8] ##1 !code_ready [*3] ##1 code_ready;
  endproperty
  a_r04: assert property (p_r04)
    else $error("pointer increment did not hold three cycles");

  property p_r03;
    take && s_r.st == OCD_ST_OP && code_byte[7:3] == 5'h05
      |-> ##4 instr_valid ##0 instr_len == LEN_ONE
          && instr_cycles == CYC_ONE && flag_update == FLG_ALL;
  endproperty
  a_r03: assert property (p_r03)
    else $error("register add not one byte one cycle");

  property p_r05;
    instr_valid && (instr_opcode == OP_MUL || instr_opcode == OP_DIV)
      |-> instr_len == LEN_ONE && instr_cycles == CYC_FIVE
          && flag_update == FLG_CY_OV;
  endproperty
  a_r05: assert property (p_r05)
    else $error("multiply or divide timing wrong");

  property p_r06;
    instr_valid && (instr_opcode == OP_ANL_DI
      || instr_opcode == OP_ORL_DI || instr_opcode == OP_XRL_DI)
      |-> instr_len == LEN_THREE && instr_cycles == CYC_THREE;
  endproperty
  a_r06: assert property (p_r06)
    else $error("logic immediate to direct timing wrong");

  property p_r07;
    instr_valid && instr_opcode == OP_MOVC_DPTR
      |-> code_addr == $past(dptr_value) + {ZERO_BYTE, $past(acc_value)}
          && instr_cycles == CYC_THREE;
  endproperty
  a_r07: assert property (p_r07)
    else $error("code table address wrong");

  property p_r08;
    instr_valid && instr_mode == OCD_MD_XRI
      |-> xdata_addr[7:0] == $past(ri_value)
          && xdata_addr[15:8] == ($past(xpage_en)
             ? $past(external_page_high_byte) : ZERO_BYTE)
          && (xdata_rd != xdata_wr);
  endproperty
  a_r08: assert property (p_r08)
    else $error("paged external address wrong");

  property p_r09;
    instr_valid && instr_mode == OCD_MD_XDPTR
      |-> xdata_addr == $past(dptr_value) && instr_len == LEN_ONE;
  endproperty
  a_r09: assert property (p_r09)
    else $error("pointer external address wrong");

  property p_r10;
    instr_valid && (instr_opcode == OP_LCALL || instr_opcode == OP_LJMP)
      |-> instr_len == LEN_THREE && instr_cycles == CYC_FOUR;
  endproperty
  a_r10: assert property (p_r10)
    else $error("long call or jump timing wrong");

  property p_r11;
    instr_valid && (instr_opcode == OP_RET || instr_opcode == OP_RETI)
      |-> instr_len == LEN_ONE && instr_cycles == CYC_FOUR;
  endproperty
  a_r11: assert property (p_r11)
    else $error("return timing wrong");

  property p_r15;
    instr_valid |-> bit_clear_on_branch == (instr_opcode == OP_JBC);
  endproperty
  a_r15: assert property (p_r15)
    else $error("bit clear flag on wrong opcode");

  property p_r19;
    instr_valid && instr_opcode == OP_NOP_ALT
      |-> instr_len == LEN_ONE && instr_cycles == CYC_ONE
          && instr_mode == OCD_MD_NONE && flag_update == FLG_NONE;
  endproperty
  a_r19: assert property (p_r19)
    else $error("reserved opcode not a no-operation");

  property p_r22;
    instr_valid && instr_mode == OCD_MD_IND
      |-> reg_index[0] == instr_opcode[0] && ind_ptr_sel == instr_opcode[0];
  endproperty
  a_r22: assert property (p_r22)
    else $error("indirect pointer select wrong");

  property p_r18;
    instr_valid && instr_opcode == OP_DJNZ_D
      |-> instr_len == LEN_THREE && instr_cycles == CYC_FOUR;
  endproperty
  a_r18: assert property (p_r18)
    else $error("direct decrement-jump timing wrong");
endmodule

// ---- dv/ocd_decode_seq_tb.sv ----
// Self-checking bench for the opcode decode sequencer
`timescale 1ns/100ps
module ocd_decode_seq_tb import ocd_pkg::*; ;
  logic        core_clk = 1'b0;
  logic        rst_n;
  logic        code_valid;
  logic [7:0]  code_byte;
  logic        code_ready;
  logic [7:0]  acc_value;
  logic [7:0]  ri_value;
  logic [15:0] dptr_value;
  logic [15:0] pc_value;
  logic [7:0]  xpage_byte;
  logic        xpage_en;
  logic        instr_valid;
  logic [7:0]  instr_opcode;
  logic [1:0]  instr_len;
  logic [2:0]  instr_cycles;
  ocd_mode_t   instr_mode;
  logic [2:0]  reg_index;
  logic        ind_ptr_sel;
  logic [2:0]  flag_update;
  logic        bit_clear_on_branch;
  logic [7:0]  operand1;
  logic [7:0]  operand2;
  logic [10:0] branch_addr11;
  logic [15:0] xdata_addr;
  logic        xdata_rd;
  logic        xdata_wr;
  logic [15:0] code_addr;
  logic [1:0]  icyc_phase;
  logic        cap_rd;
  logic        cap_wr;
  int          failures = 0;
  int          check_count = 0;
  int          cyc_cnt = 0;

  ocd_decode_seq ocd_decode_seq_inst (
    .core_clk(core_clk), .rst_n(rst_n), .code_valid(code_valid),
    .code_byte(code_byte), .code_ready(code_ready),
    .acc_value(acc_value), .ri_value(ri_value),
    .dptr_value(dptr_value), .pc_value(pc_value),
    .external_page_high_byte(xpage_byte), .xpage_en(xpage_en),
    .instr_valid(instr_valid), .instr_opcode(instr_opcode),
    .instr_len(instr_len), .instr_cycles(instr_cycles),
    .instr_mode(instr_mode), .reg_index(reg_index),
    .ind_ptr_sel(ind_ptr_sel), .flag_update(flag_update),
    .bit_clear_on_branch(bit_clear_on_branch), .operand1(operand1),
    .operand2(operand2), .branch_addr11(branch_addr11),
    .xdata_addr(xdata_addr), .xdata_rd(xdata_rd), .xdata_wr(xdata_wr),
    .code_addr(code_addr), .icyc_phase(icyc_phase)
  );

  always #2.5 core_clk = ~core_clk;

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Longest run is about 1000 clocks; generous margin for stalls
  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, got);
    check_count++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask

  // Feeds one instruction; n counts edges after the opcode edge
  task automatic run(input logic [7:0] op, input logic [4:0] lc,
                     input int stall);
    logic [7:0] bytes [3];
    int         k;
    int         n;
    int         st;
    int         nb;
    logic       rdy;
    logic       started;
    bytes = '{op, 8'hC5, 8'h3A};
    k = 0;
    n = 0;
    st = stall;
    nb = int'(lc[4:3]);
    started = 1'b0;
    code_byte <= op;
    code_valid <= 1'b1;
    forever begin
      @(negedge core_clk);
      if (started && instr_valid)
        break;
      if (n > 100)
        break;
      // A stall freezes the phase, so only check unstalled runs
      if (started && stall == 0)
        chk("phase", 16'((n + 1) % 4), 16'(icyc_phase));
      if (started)
        chk("ptr_sel", 16'(op[0]), 16'(ind_ptr_sel));
      rdy = code_ready;
      @(posedge core_clk);
      if (started)
        n++;
      if (rdy && code_valid && k < nb) begin
        k++;
        started = 1'b1;
        code_byte <= (k < 3) ? bytes[k] : ~bytes[k-1];
        if (k == nb || (k == 1 && stall > 0))
          code_valid <= 1'b0;
      end else if (rdy && !code_valid && st > 0) begin
        st--;
        if (st == 0)
          code_valid <= 1'b1;
      end
    end
    cap_rd = xdata_rd;
    cap_wr = xdata_wr;
    chk("latency", 16'(4 * lc[2:0] - 1 + stall), 16'(n));
    chk("len", 16'(lc[4:3]), 16'(instr_len));
    chk("cycles", 16'(lc[2:0]), 16'(instr_cycles));
    chk("opcode", 16'(op), 16'(instr_opcode));
    chk("reg_idx", 16'(op[2:0]), 16'(reg_index));
    chk("opnd1", 16'(nb > 1 ? 8'hC5 : 8'h00), 16'(operand1));
    chk("opnd2", 16'(nb > 2 ? 8'h3A : 8'h00), 16'(operand2));
    @(posedge core_clk);
  endtask

  task automatic run_set(input logic [4:0] lc, input int cnt,
                         input logic [95:0] ops);
    for (int i = 0; i < cnt; i++)
      run(ops[8*i +: 8], lc, 0);
  endtask

  task automatic t_table;
    run_set(LC_1_1, 12, 96'({8'h28, 8'h2F, 8'h26, 8'h27, 8'h38, 8'h3F,
            8'h36, 8'h37, 8'h98, 8'h9F, 8'h96, 8'h97}));
    run_set(LC_2_2, 6, 96'({8'h25, 8'h24, 8'h35, 8'h34, 8'h95,
            8'h94}));
    run_set(LC_1_3, 1, 96'(8'hA3));
    run_set(LC_1_5, 2, 96'({8'hA4, 8'h84}));
    run_set(LC_3_3, 3, 96'({8'h53, 8'h43, 8'h63}));
    run_set(LC_1_3, 2, 96'({8'h93, 8'h83}));
    run_set(LC_1_3, 4, 96'({8'hE2, 8'hE3, 8'hF2, 8'hF3}));
    run_set(LC_1_3, 2, 96'({8'hE0, 8'hF0}));
    run_set(LC_3_4, 1, 96'(8'h12));
    run_set(LC_1_4, 2, 96'({8'h22, 8'h32}));
    run_set(LC_2_3, 4, 96'({8'h11, 8'hF1, 8'h01, 8'hE1}));
    run_set(LC_3_4, 1, 96'(8'h02));
    run_set(LC_2_3, 5, 96'({8'h80, 8'h40, 8'h50, 8'h60,
            8'h70}));
    run_set(LC_3_4, 3, 96'({8'h10, 8'h20, 8'h30}));
    run_set(LC_1_3, 1, 96'(8'h73));
    run_set(LC_3_4, 6, 96'({8'hB5, 8'hB4, 8'hB8, 8'hBF, 8'hB6,
            8'hB7}));
    run_set(LC_2_3, 2, 96'({8'hD8, 8'hDF}));
    run_set(LC_3_4, 1, 96'(8'hD5));
    run_set(LC_1_1, 2, 96'({8'h00, 8'hA5}));
    run_set(LC_1_1, 3, 96'({8'hC3, 8'hD3, 8'hB3}));
    run_set(LC_2_2, 6, 96'({8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2,
            8'h92}));
    run_set(LC_3_3, 2, 96'({8'h85, 8'h75}));
  endtask

  task automatic t_xdata;
    ri_value <= 8'h3C;
    xpage_byte <= 8'h5A;
    xpage_en <= 1'b1;
    dptr_value <= 16'hBEEF;
    run(8'hE2, LC_1_3, 0);
    chk("xaddr", 16'h5A3C, xdata_addr);
    chk("xrdwr", 16'h0002, 16'({cap_rd, cap_wr}));
    chk("mode", 16'(OCD_MD_XRI), 16'(instr_mode));
    xpage_en <= 1'b0;
    run(8'hF3, LC_1_3, 0);
    chk("xaddr", 16'h003C, xdata_addr);
    chk("xrdwr", 16'h0001, 16'({cap_rd, cap_wr}));
    run(8'hE0, LC_1_3, 0);
    chk("xaddr", 16'hBEEF, xdata_addr);
    chk("xrdwr", 16'h0002, 16'({cap_rd, cap_wr}));
    chk("mode", 16'(OCD_MD_XDPTR), 16'(instr_mode));
    run(8'hF0, LC_1_3, 0);
    chk("xrdwr", 16'h0001, 16'({cap_rd, cap_wr}));
  endtask

  task automatic t_code;
    acc_value <= 8'hF0;
    dptr_value <= 16'h12FF;
    pc_value <= 16'h8000;
    run(8'h93, LC_1_3, 0);
    chk("caddr", 16'h13EF, code_addr);
    chk("mode", 16'(OCD_MD_CDPTR), 16'(instr_mode));
    run(8'h83, LC_1_3, 0);
    chk("caddr", 16'h80F0, code_addr);
    chk("mode", 16'(OCD_MD_CPC), 16'(instr_mode));
    run(8'h73, LC_1_3, 0);
    chk("caddr", 16'h13EF, code_addr);
  endtask

  task automatic t_flags;
    run(8'h2A, LC_1_1, 0);
    chk("flags", 16'(FLG_ALL), 16'(flag_update));
    chk("mode", 16'(OCD_MD_REG), 16'(instr_mode));
    run(8'hA4, LC_1_5, 0);
    chk("flags", 16'(FLG_CY_OV), 16'(flag_update));
    run(8'hB4, LC_3_4, 0);
    chk("flags", 16'(FLG_CY), 16'(flag_update));
    run(8'h27, LC_1_1, 0);
    chk("mode", 16'(OCD_MD_IND), 16'(instr_mode));
    run(8'h10, LC_3_4, 0);
    chk("bitclr", 16'h0001, 16'(bit_clear_on_branch));
    run(8'h20, LC_3_4, 0);
    chk("bitclr", 16'h0000, 16'(bit_clear_on_branch));
  endtask

  task automatic t_branch;
    run(8'h21, LC_2_3, 0);
    chk("addr11", 16'h01C5, 16'(branch_addr11));
    run(8'hF1, LC_2_3, 0);
    chk("addr11", 16'h07C5, 16'(branch_addr11));
  endtask

  // Late operand must stretch the instruction, not corrupt it
  task automatic t_stall;
    run(8'h75, LC_3_3, 3);
  endtask

  initial begin
    rst_n = 1'b0;
    code_valid = 1'b0;
    code_byte = 8'h00;
    acc_value = 8'h00;
    ri_value = 8'h00;
    dptr_value = 16'h0000;
    pc_value = 16'h0000;
    xpage_byte = 8'h00;
    xpage_en = 1'b0;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    chk("rst_ready", 16'h0001, 16'(code_ready));
    chk("rst_valid", 16'h0000, 16'(instr_valid));
    @(posedge core_clk);
    rst_n <= 1'b1;
    t_table();
    t_xdata();
    t_code();
    t_flags();
    t_branch();
    t_stall();
    tally_and_finish();
  end
endmodule
